// >>> rtl/cftc_params.svh
// Purpose: constants for converter fault trip control
// Assumes: 10 MHz clk
// Notes:   offsets are byte addresses on the register bus
`ifndef CFTC_PARAMS_SVH
`define CFTC_PARAMS_SVH
`define CFTC_CLK_HZ          10000000
`define CFTC_TICK_HZ         50000
`define CFTC_TICK_CYC        (`CFTC_CLK_HZ / `CFTC_TICK_HZ)
`define CFTC_ADR_W           6
`define CFTC_OFF_CTRL        6'h00
`define CFTC_OFF_STATUS      6'h04
`define CFTC_OFF_CLEAR       6'h08
`define CFTC_OFF_ENABLE      6'h0c
`define CFTC_OFF_REF_PH1     6'h10
`define CFTC_OFF_REF_PH2     6'h14
`define CFTC_OFF_REF_OUT     6'h18
`define CFTC_OFF_SHARE_LIM   6'h1c
`define CFTC_OFF_QUAL        6'h20
`define CFTC_OFF_STATE       6'h24
`define CFTC_OFF_VOUT        6'h28
`define CFTC_OFF_MODE_LIM    6'h2c
`define CFTC_CTRL_OVP        0
`define CFTC_CTRL_VIN_BAD    1
`define CFTC_CTRL_FAST_REQ   2
`define CFTC_CTRL_FREQ_CHG   3
`define CFTC_REF_RST         12'hfff
`define CFTC_SHARE_RST       12'hfff
`define CFTC_QUAL_RST        16'h03e8
`define CFTC_NEV             6
`endif

// >>> rtl/cftc_pkg.sv
// Purpose: types for converter fault trip control
// Assumes: none
// Notes:   drive outputs travel as one struct
`default_nettype none
package cftc_pkg;
   typedef struct packed {
      logic ph1Hs;
      logic ph1Ls;
      logic ph1SrA;
      logic ph1SrB;
      logic ph2Hs;
      logic ph2Ls;
      logic ph2SrA;
      logic ph2SrB;
   } cftc_drive_s;
   typedef enum logic [1:0] {
      CFTC_RUN   = 2'b00,
      CFTC_QUAL  = 2'b01,
      CFTC_HALT  = 2'b11
   } cftc_vin_e;
endpackage : cftc_pkg
`default_nettype wire

// >>> rtl/cftc_sync.sv
// Purpose: three-stage pin synchroniser with agreement check
// Assumes: input is asynchronous to clk
// Notes:   first stage read only by the second
`default_nettype none
module cftc_sync (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic pinIn,
   output logic      level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         s3_q  <= 1'b0;
         level <= 1'b0;
      end else begin
         s1_q <= pinIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level <= s3_q;
         end
      end
   end
endmodule : cftc_sync // cftc_sync
`default_nettype wire

// >>> rtl/cftc_top.sv
// Purpose: fault supervision and trip logic of a two-phase resonant converter
// Assumes: 10 MHz clk, async active-high reset, classic wishbone slave
// Notes:
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`include "cftc_params.svh"
`default_nettype none
module cftc_top (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic                 wbCycI,
   input  wire logic                 wbStbI,
   input  wire logic                 wbWeI,
   input  wire logic [3:0]           wbSelI,
   input  wire logic [5:0]           wbAdrI,
   input  wire logic [31:0]          wbDatI,
   output logic      [31:0]          wbDatO,
   output logic                      wbAckO,
   input  wire logic                 ph1CmpPin,
   input  wire logic                 ph2CmpPin,
   input  wire logic                 outCmpPin,
   input  wire logic [11:0]          ph1Current,
   input  wire logic [11:0]          ph2Current,
   input  wire logic [11:0]          outCurrent,
   input  wire logic [11:0]          voutSample,
   input  wire logic                 voutValid,
   input  wire logic                 masterPeriod,
   input  wire cftc_pkg::cftc_drive_s pwmIn,
   output cftc_pkg::cftc_drive_s     driveOut,
   output logic [11:0]               ph1RefDac,
   output logic [11:0]               ph2RefDac,
   output logic [11:0]               outRefDac,
   output logic                      faultLed,
   output logic                      controlTick,
   output logic                      fastUpdate,
   output logic [11:0]               voutFeedback,
   output logic                      lowLoadMode,
   output logic                      irq
);
   import cftc_pkg::*;

   logic        ph1Sync;
   logic        ph2Sync;
   logic        outSync;
   logic [11:0] refPh1_q;
   logic [11:0] refPh2_q;
   logic [11:0] refOut_q;
   logic [11:0] shareLim_q;
   logic [11:0] modeLim_q;
   logic [15:0] qual_q;
   logic [3:0]  ctrl_q;
   logic [5:0]  status_q;
   logic [5:0]  enable_q;
   logic        trip_q;
   logic        shareBad_q;
   logic [15:0] qualCnt_q;
   logic [15:0] tickCnt_q;
   logic        fastPend_q;
   logic        periodDly_q;
   logic [11:0] vout_q;
   cftc_vin_e   vinState_q;
   logic        wrEn;
   logic        rdEn;
   logic        cmpHit;
   logic        tripNow;
   logic [11:0] diff;
   logic [5:0]  events;
   logic [31:0] rdData;
   logic [31:0] wrMask;
   logic        wrCtrl;
   logic        wrEnable;
   logic        wrRefPh1;
   logic        wrRefPh2;
   logic        wrRefOut;
   logic        wrShare;
   logic        wrMode;
   logic        wrQual;
   logic        wrClear;

   // comparator pins, three-stage agreement synchronisers
   cftc_sync u_sync_ph1 (.clk(clk), .reset(reset), .pinIn(ph1CmpPin), .level(ph1Sync));
   cftc_sync u_sync_ph2 (.clk(clk), .reset(reset), .pinIn(ph2CmpPin), .level(ph2Sync));
   cftc_sync u_sync_out (.clk(clk), .reset(reset), .pinIn(outCmpPin), .level(outSync));

   // bus decode
   assign wrEn   = wbCycI && wbStbI && wbWeI && !wbAckO;
   assign rdEn   = wbCycI && wbStbI && !wbWeI && !wbAckO;
   assign wrMask = {{8{wbSelI[3]}}, {8{wbSelI[2]}}, {8{wbSelI[1]}}, {8{wbSelI[0]}}};

   // one write strobe per register
   assign wrCtrl   = wrEn && (wbAdrI == `CFTC_OFF_CTRL);
   assign wrEnable = wrEn && (wbAdrI == `CFTC_OFF_ENABLE);
   assign wrRefPh1 = wrEn && (wbAdrI == `CFTC_OFF_REF_PH1);
   assign wrRefPh2 = wrEn && (wbAdrI == `CFTC_OFF_REF_PH2);
   assign wrRefOut = wrEn && (wbAdrI == `CFTC_OFF_REF_OUT);
   assign wrShare  = wrEn && (wbAdrI == `CFTC_OFF_SHARE_LIM);
   assign wrMode   = wrEn && (wbAdrI == `CFTC_OFF_MODE_LIM);
   assign wrQual   = wrEn && (wbAdrI == `CFTC_OFF_QUAL);
   assign wrClear  = wrEn && (wbAdrI == `CFTC_OFF_CLEAR) && wbSelI[0];

   // trip sources
   assign cmpHit  = ph1Sync || ph2Sync || outSync;
   assign tripNow = cmpHit || ctrl_q[`CFTC_CTRL_OVP];
   assign diff    = (ph1Current > ph2Current) ? (ph1Current - ph2Current)
                                              : (ph2Current - ph1Current);
   assign events  = {shareBad_q, ctrl_q[`CFTC_CTRL_VIN_BAD], ctrl_q[`CFTC_CTRL_OVP],
                     outSync, ph2Sync, ph1Sync};

   // software control bits; fast request and frequency change clear themselves
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_q <= 4'h0;
      end else if (wrCtrl) begin
         ctrl_q <= (ctrl_q & ~wrMask[3:0]) | (wbDatI[3:0] & wrMask[3:0]);
      end else begin
         ctrl_q[`CFTC_CTRL_FAST_REQ] <= 1'b0;
         ctrl_q[`CFTC_CTRL_FREQ_CHG] <= 1'b0;
      end
   end

   // interrupt enables
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         enable_q <= 6'h00;
      end else if (wrEnable) begin
         enable_q <= (enable_q & ~wrMask[5:0]) | (wbDatI[5:0] & wrMask[5:0]);
      end
   end

   // comparator trip references
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         refPh1_q <= `CFTC_REF_RST;
         refPh2_q <= `CFTC_REF_RST;
         refOut_q <= `CFTC_REF_RST;
      end else begin
         if (wrRefPh1) begin
            refPh1_q <= (refPh1_q & ~wrMask[11:0]) | (wbDatI[11:0] & wrMask[11:0]);
         end
         if (wrRefPh2) begin
            refPh2_q <= (refPh2_q & ~wrMask[11:0]) | (wbDatI[11:0] & wrMask[11:0]);
         end
         if (wrRefOut) begin
            refOut_q <= (refOut_q & ~wrMask[11:0]) | (wbDatI[11:0] & wrMask[11:0]);
         end
      end
   end

   // sharing, mode and qualification limits
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         shareLim_q <= `CFTC_SHARE_RST;
         modeLim_q  <= 12'h000;
         qual_q     <= `CFTC_QUAL_RST;
      end else begin
         if (wrShare) begin
            shareLim_q <= (shareLim_q & ~wrMask[11:0]) | (wbDatI[11:0] & wrMask[11:0]);
         end
         if (wrMode) begin
            modeLim_q <= (modeLim_q & ~wrMask[11:0]) | (wbDatI[11:0] & wrMask[11:0]);
         end
         if (wrQual) begin
            qual_q <= (qual_q & ~wrMask[15:0]) | (wbDatI[15:0] & wrMask[15:0]);
         end
      end
   end

   // latched trip, released by reset only
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         trip_q <= 1'b0;
      end else if (tripNow) begin
         trip_q <= 1'b1;
      end
   end

   // input voltage window supervision with qualification
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         vinState_q <= CFTC_HALT;
         qualCnt_q  <= 16'h0000;
      end else begin
         unique case (vinState_q)
            CFTC_RUN: begin
               if (ctrl_q[`CFTC_CTRL_VIN_BAD]) begin
                  vinState_q <= CFTC_HALT;
               end
            end
            CFTC_HALT: begin
               qualCnt_q <= 16'h0000;
               if (!ctrl_q[`CFTC_CTRL_VIN_BAD]) begin
                  vinState_q <= CFTC_QUAL;
               end
            end
            CFTC_QUAL: begin
               if (ctrl_q[`CFTC_CTRL_VIN_BAD]) begin
                  vinState_q <= CFTC_HALT;
               end else if (qualCnt_q >= qual_q) begin
                  vinState_q <= CFTC_RUN;
               end else if (tickCnt_q == 16'h0000) begin
                  qualCnt_q <= qualCnt_q + 16'h0001;
               end
            end
            default: vinState_q <= CFTC_HALT;
         endcase
      end
   end

   // drive gating and fault indicator
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         driveOut <= '0;
         faultLed <= 1'b0;
      end else begin
         if (trip_q || tripNow || vinState_q != CFTC_RUN) begin
            driveOut <= '0;
         end else begin
            driveOut <= pwmIn;
         end
         faultLed <= trip_q || tripNow;
      end
   end

   // reference outputs and current sharing check
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ph1RefDac  <= `CFTC_REF_RST;
         ph2RefDac  <= `CFTC_REF_RST;
         outRefDac  <= `CFTC_REF_RST;
         shareBad_q <= 1'b0;
      end else begin
         ph1RefDac  <= refPh1_q;
         ph2RefDac  <= refPh2_q;
         outRefDac  <= refOut_q;
         shareBad_q <= diff > shareLim_q;
      end
   end

   // 50 kHz control tick and voltage feedback capture
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tickCnt_q    <= 16'h0000;
         controlTick  <= 1'b0;
         vout_q       <= 12'h000;
         voutFeedback <= 12'h000;
         lowLoadMode  <= 1'b0;
      end else begin
         if (voutValid) begin
            vout_q <= voutSample;
         end
         controlTick <= 1'b0;
         if (tickCnt_q == 16'((`CFTC_TICK_CYC) - 1)) begin
            tickCnt_q    <= 16'h0000;
            controlTick  <= 1'b1;
            voutFeedback <= vout_q;
            lowLoadMode  <= outCurrent < modeLim_q;
         end else begin
            tickCnt_q <= tickCnt_q + 16'h0001;
         end
      end
   end

   // fast update on master period edge when requested
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fastPend_q  <= 1'b0;
         periodDly_q <= 1'b0;
         fastUpdate  <= 1'b0;
      end else begin
         periodDly_q <= masterPeriod;
         fastUpdate  <= 1'b0;
         if (masterPeriod && !periodDly_q && fastPend_q) begin
            fastUpdate <= 1'b1;
            fastPend_q <= 1'b0;
         end
         if (ctrl_q[`CFTC_CTRL_FAST_REQ] || ctrl_q[`CFTC_CTRL_FREQ_CHG]) begin
            fastPend_q <= 1'b1;
         end
      end
   end

   // sticky status, set wins over clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status_q <= 6'h00;
      end else begin
         if (wrClear) begin
            status_q <= (status_q & ~wbDatI[5:0]) | events;
         end else begin
            status_q <= status_q | events;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & enable_q);
      end
   end

   // read mux
   always_comb begin
      rdData = 32'h0000_0000;
      unique case (wbAdrI)
         `CFTC_OFF_CTRL:      rdData = {28'h0, ctrl_q};
         `CFTC_OFF_STATUS:    rdData = {26'h0, status_q};
         `CFTC_OFF_ENABLE:    rdData = {26'h0, enable_q};
         `CFTC_OFF_REF_PH1:   rdData = {20'h0, refPh1_q};
         `CFTC_OFF_REF_PH2:   rdData = {20'h0, refPh2_q};
         `CFTC_OFF_REF_OUT:   rdData = {20'h0, refOut_q};
         `CFTC_OFF_SHARE_LIM: rdData = {20'h0, shareLim_q};
         `CFTC_OFF_QUAL:      rdData = {16'h0, qual_q};
         `CFTC_OFF_STATE:     rdData = {27'h0, lowLoadMode, shareBad_q, vinState_q, trip_q};
         `CFTC_OFF_VOUT:      rdData = {20'h0, voutFeedback};
         `CFTC_OFF_MODE_LIM:  rdData = {20'h0, modeLim_q};
         default:             rdData = 32'h0000_0000;
      endcase
   end

   // single-cycle ack, one wait state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wbAckO <= 1'b0;
         wbDatO <= 32'h0000_0000;
      end else begin
         wbAckO <= wrEn || rdEn;
         wbDatO <= rdEn ? rdData : 32'h0000_0000;
      end
   end
endmodule : cftc_top // cftc_top
`default_nettype wire

// >>> tb/cftc_stage_model.sv
// Purpose: sensing side model: current comparators and vout adc
// Assumes: currents are set by the bench
// Notes:   comparator delay arbitrary, asynchronous to clk
`default_nettype none
module cftc_stage_model (
   input  wire logic        clk,
   input  wire logic [11:0] ph1Current,
   input  wire logic [11:0] ph2Current,
   input  wire logic [11:0] outCurrent,
   input  wire logic [11:0] ph1RefDac,
   input  wire logic [11:0] ph2RefDac,
   input  wire logic [11:0] outRefDac,
   output logic             ph1CmpPin,
   output logic             ph2CmpPin,
   output logic             outCmpPin,
   output logic [11:0]      voutSample,
   output logic             voutValid
);
   timeunit 1ns;
   timeprecision 1ns;
   assign #13 ph1CmpPin = ph1Current > ph1RefDac;
   assign #13 ph2CmpPin = ph2Current > ph2RefDac;
   assign #17 outCmpPin = outCurrent > outRefDac;
   assign voutSample = 12'h6b1;
   always @(posedge clk) voutValid <= (voutValid !== 1'b1);
endmodule // cftc_stage_model
`default_nettype wire

// >>> tb/cftc_top_properties.sv
// Purpose: port checker of converter fault trip control
// Assumes: one clock, async active-high reset
// Notes:   bound to cftc_top below
`include "cftc_params.svh"
`default_nettype none
module cftc_top_properties (
   input wire logic                  clk,
   input wire logic                  reset,
   input wire logic                  wbCycI,
   input wire logic                  wbStbI,
   input wire logic                  wbAckO,
   input wire logic [31:0]           wbDatO,
   input wire logic                  ph1CmpPin,
   input wire logic                  ph2CmpPin,
   input wire logic                  outCmpPin,
   input wire logic                  masterPeriod,
   input wire cftc_pkg::cftc_drive_s pwmIn,
   input wire cftc_pkg::cftc_drive_s driveOut,
   input wire logic                  faultLed,
   input wire logic                  controlTick,
   input wire logic                  fastUpdate
);
   timeunit 1ns;
   timeprecision 1ns;
   import cftc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   int unsigned tickCnt_q;
   logic        tickSeen_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tickCnt_q <= 0;
         tickSeen_q <= 1'b0;
      end else begin
         tickCnt_q <= controlTick ? 0 : tickCnt_q + 1;
         tickSeen_q <= tickSeen_q | controlTick;
      end
   end
   sequence pinRise;
      $rose(ph1CmpPin || ph2CmpPin || outCmpPin);
   endsequence
   sequence tripLand;
      ##[3:6] faultLed;
   endsequence
   a_bus_answer: assert property (wbCycI && wbStbI && !wbAckO |=> wbAckO)
      else $error("ack missing");
   a_ack_single: assert property (wbAckO |=> !wbAckO)
      else $error("ack too long");
   a_data_idle: assert property (!wbAckO |-> wbDatO == '0)
      else $error("read data without ack");
   a_trip_gate: assert property (faultLed |-> driveOut == '0)
      else $error("drive high while tripped");
   a_trip_hold: assert property (faultLed |=> faultLed)
      else $error("trip released");
   a_trip_delay: assert property (pinRise |-> tripLand)
      else $error("trip late");
   a_trip_sync: assert property (!faultLed ##0 pinRise |=> !faultLed [*2])
      else $error("trip skips synchroniser");
   a_tick_period: assert property (controlTick && tickSeen_q |-> tickCnt_q == 199)
      else $error("tick period wrong");
   a_tick_bound: assert property (tickCnt_q <= `CFTC_TICK_CYC)
      else $error("tick missing");
   a_drive_follow: assert property ((driveOut & ~$past(pwmIn)) == '0)
      else $error("drive without pwm");
   a_fast_cause: assert property (fastUpdate |-> $past(masterPeriod) || $past(masterPeriod, 2))
      else $error("fast update off period");
   a_fast_single: assert property (fastUpdate |=> !fastUpdate)
      else $error("fast update too long");
endmodule // cftc_top_properties
bind cftc_top cftc_top_properties cftc_top_properties_inst (.clk, .reset, .wbCycI, .wbStbI,
   .wbAckO, .wbDatO, .ph1CmpPin, .ph2CmpPin, .outCmpPin, .masterPeriod, .pwmIn, .driveOut,
   .faultLed, .controlTick, .fastUpdate);
`default_nettype wire

// >>> tb/cftc_top_tb.sv
// Purpose: self-checking bench of converter fault trip control
// Assumes: classic wishbone master, qualification shortened to 2 ticks
// Notes:   each trip source gets its own reset
`include "cftc_params.svh"
`default_nettype none
module cftc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import cftc_pkg::*;
   logic        clk = 0, reset = 1, wbCycI = 0, wbStbI = 0, wbWeI = 0, masterPeriod = 0;
   logic [3:0]  wbSelI = 4'hf;
   logic [5:0]  wbAdrI = '0;
   logic [31:0] wbDatI = '0, wbDatO, rd;
   logic [11:0] ph1Current = '0, ph2Current = '0, outCurrent = '0, voutSample;
   logic [11:0] ph1RefDac, ph2RefDac, outRefDac, voutFeedback;
   logic        wbAckO, ph1CmpPin, ph2CmpPin, outCmpPin, voutValid, faultLed;
   logic        controlTick, fastUpdate, lowLoadMode, irq;
   cftc_drive_s pwmIn = 8'ha5, driveOut;
   int          errors = 0, checks = 0, cycles = 0, n, m;
   always #50 clk = ~clk;
   cftc_top cftc_top_inst (.clk, .reset, .wbCycI, .wbStbI, .wbWeI, .wbSelI, .wbAdrI,
      .wbDatI, .wbDatO, .wbAckO, .ph1CmpPin, .ph2CmpPin, .outCmpPin, .ph1Current,
      .ph2Current, .outCurrent, .voutSample, .voutValid, .masterPeriod, .pwmIn, .driveOut,
      .ph1RefDac, .ph2RefDac, .outRefDac, .faultLed, .controlTick, .fastUpdate,
      .voutFeedback, .lowLoadMode, .irq);
   cftc_stage_model cftc_stage_model_inst (.clk, .ph1Current, .ph2Current, .outCurrent,
      .ph1RefDac, .ph2RefDac, .outRefDac, .ph1CmpPin, .ph2CmpPin, .outCmpPin, .voutSample,
      .voutValid);
   task automatic final_report;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tk(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      wbCycI <= 1'b1;
      wbStbI <= 1'b1;
      wbWeI <= w;
      wbAdrI <= a;
      wbDatI <= d;
      n = 0;
      do @(posedge clk); while (wbAckO !== 1'b1 && ++n < 20);
      rd = wbDatO;
      wbCycI <= 1'b0;
      wbStbI <= 1'b0;
      if (n == 20) chk(0, 1);
   endtask
   task automatic waitTick;
      n = 0;
      do @(posedge clk); while (controlTick !== 1'b1 && ++n < 300);
   endtask
   task automatic waitRun;
      m = 0;
      do begin
         tk(40);
         wb(0, `CFTC_OFF_STATE, 0);
      end while (rd[2:1] !== 2'b00 && ++m < 40);
      chk(rd[2:1], 0);
   endtask
   task automatic setCur(input int k, input logic [11:0] v);
      ph1Current <= k == 0 ? v : '0;
      ph2Current <= k == 1 ? v : '0;
      outCurrent <= k == 2 ? v : '0;
   endtask
   task automatic doReset;
      reset <= 1'b1;
      tk(2);
      reset <= 1'b0;
      chk(ph1RefDac, 12'hfff);
      chk(driveOut, 0);
      wb(0, `CFTC_OFF_QUAL, 0);
      chk(rd, 32'h3e8);
      wb(1, `CFTC_OFF_QUAL, 2);
      wb(1, `CFTC_OFF_ENABLE, 32'h3f);
      waitRun;
      chk(driveOut, pwmIn);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         final_report;
      end
   end
   initial begin
      for (int k = 0; k < 4; k++) begin
         doReset;
         wb(1, 6'(`CFTC_OFF_REF_PH1 + 4 * k), 32'h400);
         setCur(k, 12'h400);
         tk(10);
         chk(faultLed, 0);
         if (k == 2) chk(outRefDac, 12'h400);
         if (k == 1) chk(ph2RefDac, 12'h400);
         setCur(k, 12'h401);
         if (k == 3) wb(1, `CFTC_OFF_CTRL, 1);
         n = 0;
         while (faultLed !== 1'b1 && n++ < 10) @(posedge clk);
         chk(faultLed, 1);
         chk(driveOut, 0);
         tk(2);
         chk(irq, 1);
         setCur(k, 0);
         wb(1, `CFTC_OFF_CTRL, 0);
         tk(8);
         chk(faultLed, 1);
         wb(0, `CFTC_OFF_STATUS, 0);
         chk(rd, 1 << k);
         wb(1, `CFTC_OFF_CLEAR, 1 << k);
         wb(0, `CFTC_OFF_STATUS, 0);
         chk(rd, 0);
         tk(2);
         chk(irq, 0);
      end
      doReset;
      wb(0, 6'h3c, 0);
      chk(rd, 0);
      wb(1, `CFTC_OFF_CTRL, 2);
      wb(0, `CFTC_OFF_CTRL, 0);
      chk(rd, 32'h2);
      tk(2);
      chk(driveOut, 0);
      chk(irq, 1);
      wb(1, `CFTC_OFF_ENABLE, 0);
      tk(2);
      chk(irq, 0);
      wb(1, `CFTC_OFF_CTRL, 0);
      wb(0, `CFTC_OFF_STATE, 0);
      chk(rd[2:1], 2'b01);
      chk(driveOut, 0);
      waitRun;
      wb(1, `CFTC_OFF_SHARE_LIM, 32'h10);
      wb(1, `CFTC_OFF_MODE_LIM, 32'h100);
      ph1Current <= 12'h120;
      ph2Current <= 12'h100;
      outCurrent <= 12'h050;
      waitTick;
      waitTick;
      tk(3);
      wb(0, `CFTC_OFF_STATUS, 0);
      chk(rd[5], 1);
      chk(lowLoadMode, 1);
      chk(voutFeedback, 12'h6b1);
      wb(0, `CFTC_OFF_VOUT, 0);
      chk(rd, 32'h6b1);
      wb(0, `CFTC_OFF_MODE_LIM, 0);
      chk(rd, 32'h100);
      for (int k = 0; k < 3; k++) begin
         if (k > 0) wb(1, `CFTC_OFF_CTRL, 32'h2 << k);
         tk(3);
         masterPeriod <= 1'b1;
         m = 0;
         repeat (6) begin
            @(posedge clk);
            masterPeriod <= 1'b0;
            m += (fastUpdate === 1'b1);
         end
         chk(m, k > 0);
      end
      final_report;
   end
endmodule // cftc_top_tb
`default_nettype wire
